// file: design/eebw_pkg.sv
// Shared constants of the byte-wide data EEPROM write controller
package eebw_pkg;
  // Special-function register addresses
  localparam logic [7:0]  INTERRUPT_FLAGS_ADDR   = 8'h95;
  localparam logic [7:0]  CTRL_ADDR     = 8'hc9;
  localparam logic [7:0]  AUX_ADDR      = 8'hf7;
  // Field positions
  localparam int          FIN_BIT       = 6;
  localparam int          BUSY_BIT      = 5;
  localparam int          WE_BIT        = 5;
  localparam int          TO_BIT        = 3;
  localparam int          WDT_LSB       = 6;
  localparam int          AUX_MID_LSB   = 4;
  localparam int          TSEL_LSB      = 1;
  // Control key and reset values
  localparam logic [7:0]  WE_KEY        = 8'he2;
  localparam logic [1:0]  WDT_RST       = 2'h0;
  localparam logic [1:0]  AUX_MID_RST   = 2'h0;
  localparam logic [1:0]  TSEL_RST      = 2'h3;
  // External data window of the array
  localparam logic [7:0]  EE_PAGE       = 8'hee;
  localparam int          EE_DEPTH      = 256;
  // Timing, clock at 100 MHz
  localparam int          CLK_PERIOD_NS = 10;
  localparam longint      PROG_NS       = 1200000;
  localparam longint      TO1_NS        = 6900000;
  localparam longint      TO2_NS        = 27000000;
  localparam longint      TO3_NS        = 55000000;
  localparam int          READ_NS       = 300;
  localparam int          PROG_CYCLES   = int'(PROG_NS / CLK_PERIOD_NS);
  localparam int          TO1_CYCLES    = int'(TO1_NS / CLK_PERIOD_NS);
  localparam int          TO2_CYCLES    = int'(TO2_NS / CLK_PERIOD_NS);
  localparam int          TO3_CYCLES    = int'(TO3_NS / CLK_PERIOD_NS);
  localparam int          READ_CYCLES   = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W         = 24;
  // Programming engine states
  typedef enum logic [0:0] {
    EEBW_IDLE = 1'b0,
    EEBW_PROG = 1'b1
  } eebw_state_e;
endpackage

// file: design/eebw_ctrl.sv
// Operation
// - 256 bytes at EE00h-EEFFh, bytewise access
// - External store to array starts write
// - Programming time is a parameter
// - CPU never stalled during programming
// - Completion sets write-finish flag bit 6
// - ISR entry clears write-finish flag
// - Writing BFh clears only finish flag
// - Zero clears flag, one keeps it
// - Busy flag bit 5 while writing
// - Load returns stored byte, 300 ns
// - E2h sets write-enable, else clears
// - Programming allowed only with write-enable
// - Timeout flag set, cleared without enable
// - Timeout select: off, 6.9/27/55 ms
`timescale 1ns/1ps
`default_nettype none
module eebw_ctrl #(
  parameter int unsigned PROG_CYCLES = eebw_pkg::PROG_CYCLES,
  parameter int unsigned TO1_CYCLES  = eebw_pkg::TO1_CYCLES,
  parameter int unsigned TO2_CYCLES  = eebw_pkg::TO2_CYCLES,
  parameter int unsigned TO3_CYCLES  = eebw_pkg::TO3_CYCLES
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  // Special-function register port
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic        sfr_wr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  input  wire logic        sfr_rd_i,
  output logic      [7:0]  sfr_rdata_o,
  // External data port
  input  wire logic [15:0] x_addr_i,
  input  wire logic        x_wr_i,
  input  wire logic [7:0]  x_wdata_i,
  input  wire logic        x_rd_i,
  output logic      [7:0]  x_rdata_o,
  output logic             x_rvalid_o,
  // Interrupt service entry
  input  wire logic        isr_enter_i,
  // Status and control levels
  output logic             write_finish_flag_o,
  output logic             write_busy_flag_o,
  output logic             write_enable_flag_o,
  output logic             write_timeout_flag_o,
  output logic      [1:0]  watchdog_reset_control_o
);
  localparam int CW = eebw_pkg::CNT_W;
  localparam int RD_DLY = eebw_pkg::READ_CYCLES;
  localparam int RD_M1  = RD_DLY - 1;  // Edges from the quiet cycle to the result

  // Parameter checks
  if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << CW) || TO1_CYCLES < 1 ||
      TO2_CYCLES < 1 || TO3_CYCLES < 1 || TO3_CYCLES >= (1 << CW) ||
      TO1_CYCLES >= (1 << CW) || TO2_CYCLES >= (1 << CW) || RD_DLY < 2) begin : g_chk
    $error("eebw_ctrl: cycle count out of range");
  end

  // State of the engine and flags
  eebw_pkg::eebw_state_e state_r, state_nxt;
  logic [CW-1:0] prog_cnt_r, prog_cnt_nxt;
  logic [CW-1:0] tmo_cnt_r, tmo_cnt_nxt;
  logic [7:0]    wr_addr_r, wr_addr_nxt;
  logic [7:0]    wr_data_r, wr_data_nxt;
  logic          fin_r, fin_nxt;
  logic          we_r, we_nxt;
  logic          to_r, to_nxt;
  logic [1:0]    wdt_r, wdt_nxt;
  logic [1:0]    aux_mid_r, aux_mid_nxt;
  logic [1:0]    tsel_r, tsel_nxt;
  logic [7:0]    sfr_rdata_nxt;
  logic [7:0]    rd_addr_r, rd_addr_nxt;
  logic [4:0]    rd_cnt_r, rd_cnt_nxt;
  logic [7:0]    x_rdata_nxt;
  logic          x_rvalid_nxt;
  logic [7:0]    mem_r [eebw_pkg::EE_DEPTH];

  // Decode of accesses
  logic          ee_hit, wr_start, done_evt, tmo_evt;
  logic          interrupt_flags_wr, ctrl_wr, aux_wr;
  logic [CW-1:0] tmo_lim;

  assign ee_hit    = x_addr_i[15:8] == eebw_pkg::EE_PAGE;
  assign wr_start  = x_wr_i && ee_hit && we_r && state_r == eebw_pkg::EEBW_IDLE;
  assign interrupt_flags_wr = sfr_wr_i && sfr_addr_i == eebw_pkg::INTERRUPT_FLAGS_ADDR;
  assign ctrl_wr   = sfr_wr_i && sfr_addr_i == eebw_pkg::CTRL_ADDR;
  assign aux_wr    = sfr_wr_i && sfr_addr_i == eebw_pkg::AUX_ADDR;

  // Timeout limit from the select field
  always_comb begin
    unique case (tsel_r)
      2'h1:    tmo_lim = CW'(TO1_CYCLES - 1);
      2'h2:    tmo_lim = CW'(TO2_CYCLES - 1);
      default: tmo_lim = CW'(TO3_CYCLES - 1);
    endcase
  end
  assign done_evt = state_r == eebw_pkg::EEBW_PROG && prog_cnt_r == CW'(PROG_CYCLES - 1);
  assign tmo_evt  = state_r == eebw_pkg::EEBW_PROG && tsel_r != 2'h0 &&
                    tmo_cnt_r == tmo_lim && !done_evt;

  // Programming engine, runs beside the CPU with no wait signal
  always_comb begin
    state_nxt    = state_r;
    prog_cnt_nxt = prog_cnt_r;
    tmo_cnt_nxt  = tmo_cnt_r;
    wr_addr_nxt  = wr_addr_r;
    wr_data_nxt  = wr_data_r;
    unique case (state_r)
      eebw_pkg::EEBW_IDLE: begin
        if (wr_start) begin
          state_nxt    = eebw_pkg::EEBW_PROG;
          prog_cnt_nxt = '0;
          tmo_cnt_nxt  = '0;
          wr_addr_nxt  = x_addr_i[7:0];
          wr_data_nxt  = x_wdata_i;
        end
      end
      eebw_pkg::EEBW_PROG: begin
        prog_cnt_nxt = prog_cnt_r + 1'b1;
        tmo_cnt_nxt  = tmo_cnt_r + 1'b1;
        if (done_evt || tmo_evt) begin
          state_nxt = eebw_pkg::EEBW_IDLE;
        end
      end
    endcase
  end

  // Flags and register fields
  always_comb begin
    fin_nxt     = fin_r;
    we_nxt      = we_r;
    wdt_nxt     = wdt_r;
    aux_mid_nxt = aux_mid_r;
    tsel_nxt    = tsel_r;
    if ((interrupt_flags_wr && !sfr_wdata_i[eebw_pkg::FIN_BIT]) || isr_enter_i) begin
      fin_nxt = 1'b0;
    end
    if (done_evt) begin
      fin_nxt = 1'b1;
    end
    if (ctrl_wr) begin
      we_nxt = sfr_wdata_i == eebw_pkg::WE_KEY;
    end
    if (aux_wr) begin
      wdt_nxt     = sfr_wdata_i[eebw_pkg::WDT_LSB +: 2];
      aux_mid_nxt = sfr_wdata_i[eebw_pkg::AUX_MID_LSB +: 2];
      tsel_nxt    = sfr_wdata_i[eebw_pkg::TSEL_LSB +: 2];
    end
    to_nxt = (to_r || tmo_evt) && we_nxt;
  end

  // Register read data
  always_comb begin
    sfr_rdata_nxt = sfr_rdata_o;
    if (sfr_rd_i) begin
      sfr_rdata_nxt = 8'h00;
      unique case (sfr_addr_i)
        eebw_pkg::INTERRUPT_FLAGS_ADDR: begin
          sfr_rdata_nxt[eebw_pkg::FIN_BIT]  = fin_r;
          sfr_rdata_nxt[eebw_pkg::BUSY_BIT] = state_r == eebw_pkg::EEBW_PROG;
        end
        eebw_pkg::CTRL_ADDR: begin
          sfr_rdata_nxt[eebw_pkg::WE_BIT] = we_r;
          sfr_rdata_nxt[eebw_pkg::TO_BIT] = to_r;
        end
        eebw_pkg::AUX_ADDR: begin
          sfr_rdata_nxt = {wdt_r, aux_mid_r, 1'b0, tsel_r, 1'b0};
        end
        default: sfr_rdata_nxt = 8'h00;
      endcase
    end
  end

  // Array read with fixed access delay
  always_comb begin
    rd_addr_nxt  = rd_addr_r;
    rd_cnt_nxt   = rd_cnt_r;
    x_rdata_nxt  = x_rdata_o;
    x_rvalid_nxt = 1'b0;
    if (rd_cnt_r != 5'h0) begin
      rd_cnt_nxt = rd_cnt_r - 1'b1;
      if (rd_cnt_r == 5'h1) begin
        x_rvalid_nxt = 1'b1;
        x_rdata_nxt  = mem_r[rd_addr_r];
      end
    end else if (x_rd_i && ee_hit) begin
      rd_addr_nxt = x_addr_i[7:0];
      rd_cnt_nxt  = 5'(RD_DLY - 1);
    end
  end

  // State registers
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r     <= eebw_pkg::EEBW_IDLE;
      prog_cnt_r  <= '0;
      tmo_cnt_r   <= '0;
      wr_addr_r   <= 8'h00;
      wr_data_r   <= 8'h00;
      fin_r       <= 1'b0;
      we_r        <= 1'b0;
      to_r        <= 1'b0;
      wdt_r       <= eebw_pkg::WDT_RST;
      aux_mid_r   <= eebw_pkg::AUX_MID_RST;
      tsel_r      <= eebw_pkg::TSEL_RST;
      sfr_rdata_o <= 8'h00;
      rd_addr_r   <= 8'h00;
      rd_cnt_r    <= 5'h0;
      x_rdata_o   <= 8'h00;
      x_rvalid_o  <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      prog_cnt_r  <= prog_cnt_nxt;
      tmo_cnt_r   <= tmo_cnt_nxt;
      wr_addr_r   <= wr_addr_nxt;
      wr_data_r   <= wr_data_nxt;
      fin_r       <= fin_nxt;
      we_r        <= we_nxt;
      to_r        <= to_nxt;
      wdt_r       <= wdt_nxt;
      aux_mid_r   <= aux_mid_nxt;
      tsel_r      <= tsel_nxt;
      sfr_rdata_o <= sfr_rdata_nxt;
      rd_addr_r   <= rd_addr_nxt;
      rd_cnt_r    <= rd_cnt_nxt;
      x_rdata_o   <= x_rdata_nxt;
      x_rvalid_o  <= x_rvalid_nxt;
    end
  end

  // Array cell update on completion only; abandoned writes leave it
  always_ff @(posedge clock_i) begin
    if (done_evt) begin
      mem_r[wr_addr_r] <= wr_data_r;
    end
  end

  // Status outputs straight from flops
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      write_finish_flag_o      <= 1'b0;
      write_busy_flag_o        <= 1'b0;
      write_enable_flag_o      <= 1'b0;
      write_timeout_flag_o     <= 1'b0;
      watchdog_reset_control_o <= eebw_pkg::WDT_RST;
    end else begin
      write_finish_flag_o      <= fin_nxt;
      write_busy_flag_o        <= state_nxt == eebw_pkg::EEBW_PROG;
      write_enable_flag_o      <= we_nxt;
      write_timeout_flag_o     <= to_nxt;
      watchdog_reset_control_o <= wdt_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  a_write_starts: assert property (wr_start |=> write_busy_flag_o ##1 write_busy_flag_o)
    else $error("write did not start");
  a_write_gated: assert property (state_r == eebw_pkg::EEBW_IDLE && !we_r |=> !write_busy_flag_o)
    else $error("write ran without enable");
  a_finish_sets: assert property (done_evt |=> write_finish_flag_o && !write_busy_flag_o)
    else $error("finish flag not set");
  a_isr_clears: assert property (isr_enter_i && !done_evt |=> !write_finish_flag_o)
    else $error("finish flag kept on isr entry");
  a_zero_clears: assert property (interrupt_flags_wr && sfr_wdata_i == 8'hbf && !done_evt && !wr_start &&
                                  !tmo_evt |=> !write_finish_flag_o &&
                                  $stable(write_busy_flag_o))
    else $error("clear pattern misbehaved");
  a_one_keeps: assert property (fin_r && interrupt_flags_wr && sfr_wdata_i[6] && !isr_enter_i |=> fin_r)
    else $error("writing one cleared the flag");
  a_key_sets: assert property (ctrl_wr |=> write_enable_flag_o == ($past(sfr_wdata_i) == 8'he2))
    else $error("enable key decode wrong");
  a_to_needs_we: assert property (!write_enable_flag_o |-> !write_timeout_flag_o)
    else $error("timeout flag without enable");
  a_timeout_ends: assert property (tmo_evt && we_r && !ctrl_wr |=> !write_busy_flag_o && write_timeout_flag_o)
    else $error("timeout did not end write");
  a_read_delay: assert property (x_rd_i && ee_hit && rd_cnt_r == 5'h0 |=> !x_rvalid_o ##[RD_M1:RD_M1] x_rvalid_o)
    else $error("read delay wrong");
endmodule
`default_nettype wire

// file: dv/eebw_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// CPU core issuing register and external data accesses
module eebw_cpu_model (
  // Clock
  input  wire logic        clock_i,
  // Register port
  output logic      [7:0]  sfr_addr_o,
  output logic             sfr_wr_o,
  output logic      [7:0]  sfr_wdata_o,
  output logic             sfr_rd_o,
  input  wire logic [7:0]  sfr_rdata_i,
  // External data port
  output logic      [15:0] x_addr_o,
  output logic             x_wr_o,
  output logic      [7:0]  x_wdata_o,
  output logic             x_rd_o,
  input  wire logic [7:0]  x_rdata_i,
  input  wire logic        x_rvalid_i,
  input  wire logic        busy_i,
  // Interrupt entry
  output logic             isr_o
);
  // Idle levels at time zero
  initial begin
    {sfr_addr_o, sfr_wr_o, sfr_wdata_o, sfr_rd_o} = '0;
    {x_addr_o, x_wr_o, x_wdata_o, x_rd_o, isr_o} = '0;
  end
  // Register write or read, answer one edge after the taking edge
  task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clock_i);
    {sfr_addr_o, sfr_wdata_o, sfr_wr_o, sfr_rd_o} <= {a, d, wr, !wr};
    @(posedge clock_i);
    {sfr_wr_o, sfr_rd_o} <= 2'b00;
    {sfr_addr_o, sfr_wdata_o} <= ~{a, d};  // Released lines inverted
    @(posedge clock_i);
    q = sfr_rdata_i;
  endtask
  // Byte store, optionally waiting for the busy flag to drop
  task automatic xst(input logic [15:0] a, input logic [7:0] d, input logic chk);
    @(posedge clock_i);
    while (chk && busy_i) @(posedge clock_i);
    {x_addr_o, x_wdata_o, x_wr_o} <= {a, d, 1'b1};
    @(posedge clock_i);
    x_wr_o <= 1'b0;
    {x_addr_o, x_wdata_o} <= ~{a, d};
  endtask
  // Byte load, counts edges until the result arrives
  task automatic xld(input logic [15:0] a, output logic [7:0] q, output int n);
    @(posedge clock_i);
    {x_addr_o, x_rd_o} <= {a, 1'b1};
    @(posedge clock_i);
    x_rd_o <= 1'b0;
    x_addr_o <= ~a;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (!x_rvalid_i && n < 64);
    q = x_rdata_i;
  endtask
  // Entry into the write-finish service routine
  task automatic isr();
    @(posedge clock_i);
    isr_o <= 1'b1;
    @(posedge clock_i);
    isr_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: dv/eebw_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench of the EEPROM write controller
module eebw_ctrl_tb_top;
  localparam int PROG = 50;
  localparam int TO1  = 10;
  localparam int TO2  = 30;
  localparam int TO3  = 80;
  logic             clock_i;
  logic             arst_n_i;
  logic [7:0]       s_addr, s_wd, s_rd, x_wd, x_rd, sq, xq, sd;
  logic [15:0]      x_addr;
  logic             s_wr, s_rdy, x_wr, x_rdy, x_v, isr, fin, busy, we, tof;
  logic [1:0]       wdc;
  logic [7:0]       mem [256];
  logic [7:0]       ra [4] = '{8'h95, 8'hc9, 8'hf7, 8'h80};
  logic [7:0]       rv [4] = '{8'h00, 8'h00, 8'h06, 8'h00};
  int               errors, check_count;
  eebw_ctrl #(.PROG_CYCLES(PROG), .TO1_CYCLES(TO1), .TO2_CYCLES(TO2), .TO3_CYCLES(TO3)) dut_u (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .sfr_addr_i(s_addr), .sfr_wr_i(s_wr),
    .sfr_wdata_i(s_wd), .sfr_rd_i(s_rdy), .sfr_rdata_o(s_rd), .x_addr_i(x_addr),
    .x_wr_i(x_wr), .x_wdata_i(x_wd), .x_rd_i(x_rdy), .x_rdata_o(x_rd), .x_rvalid_o(x_v),
    .isr_enter_i(isr), .write_finish_flag_o(fin), .write_busy_flag_o(busy),
    .write_enable_flag_o(we), .write_timeout_flag_o(tof), .watchdog_reset_control_o(wdc));
  eebw_cpu_model cpu_u (
    .clock_i(clock_i), .sfr_addr_o(s_addr), .sfr_wr_o(s_wr), .sfr_wdata_o(s_wd),
    .sfr_rd_o(s_rdy), .sfr_rdata_i(s_rd), .x_addr_o(x_addr), .x_wr_o(x_wr),
    .x_wdata_o(x_wd), .x_rd_o(x_rdy), .x_rdata_i(x_rd), .x_rvalid_i(x_v),
    .busy_i(busy), .isr_o(isr));
  // Clock at 100 MHz
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Byte and flag comparison
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Cycle count comparison
  task automatic cmpn(input int g, input int lo, input int hi);
    check_count++;
    if (g < lo || g > hi) begin
      errors++;
      $display("wrong value at %0t: count %0d not in %0d..%0d", $time, g, lo, hi);
    end
  endtask
  // Timeout length for a select code
  function automatic int to_cycles(input logic [1:0] s);
    return (s == 2'h1) ? TO1 : (s == 2'h2) ? TO2 : (s == 2'h3) ? TO3 : 0;
  endfunction
  // Verdict and end of run
  task automatic final_report();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // One byte write with a given timeout select, then read back
  task automatic op(input logic [7:0] off, input logic [7:0] d, input logic [1:0] s);
    int n, lim;
    logic tmo;
    logic [15:0] a;
    a = {eebw_pkg::EE_PAGE, off};
    lim = to_cycles(s);
    tmo = (s != 2'h0) && (lim < PROG);
    cpu_u.sfr(1'b1, eebw_pkg::AUX_ADDR, {1'b0, off[0], 2'h0, 1'b0, s, 1'b0}, sq);
    cmp8({6'h00, wdc}, {7'h00, off[0]});
    cpu_u.sfr(1'b1, eebw_pkg::CTRL_ADDR, eebw_pkg::WE_KEY, sq);
    cpu_u.sfr(1'b0, eebw_pkg::CTRL_ADDR, 8'h00, sq);
    cmp8(sq, 8'h20);
    cpu_u.xst(a, d, 1'b1);
    cpu_u.xst(a, ~d, 1'b0);
    cpu_u.sfr(1'b0, eebw_pkg::INTERRUPT_FLAGS_ADDR, 8'h00, sq);
    cmp8(sq, 8'h20);
    n = 4;  // Busy seen here dates from the edge before
    while (busy === 1'b1 && n < 200) begin
      @(posedge clock_i);
      n++;
    end
    if (tmo) cmpn(n, lim, lim);
    else cmpn(n, PROG, PROG);
    cmp8({7'h00, fin}, {7'h00, !tmo});
    cpu_u.sfr(1'b0, eebw_pkg::INTERRUPT_FLAGS_ADDR, 8'h00, sq);
    cmp8(sq, {1'b0, !tmo, 6'h00});
    cpu_u.sfr(1'b0, eebw_pkg::CTRL_ADDR, 8'h00, sq);
    cmp8(sq, {4'h2, tmo, 3'h0});
    cpu_u.sfr(1'b1, eebw_pkg::CTRL_ADDR, 8'h00, sq);
    cmp8({6'h00, we, tof}, 8'h00);
    cpu_u.xld(a, xq, n);
    cmpn(n, 30, 30);
    if (!tmo) mem[off] = d;
    cmp8(xq, mem[off]);
    if (!tmo) begin
      cpu_u.sfr(1'b1, eebw_pkg::INTERRUPT_FLAGS_ADDR, 8'hff, sq);
      cmp8({7'h00, fin}, 8'h01);
      if (s == 2'h3) cpu_u.isr();
      else cpu_u.sfr(1'b1, eebw_pkg::INTERRUPT_FLAGS_ADDR, 8'hbf, sq);
      @(posedge clock_i);
      cmp8({7'h00, fin}, 8'h00);
    end
  endtask
  // Watchdog against a hang
  initial begin
    #500000;
    errors++;
    final_report();
  end
  // Main sequence
  initial begin
    errors = 0;
    check_count = 0;
    arst_n_i = 1'b0;
    void'($urandom(57));
    repeat (10) @(posedge clock_i);
    arst_n_i <= 1'b1;
    // Reset values and an unmapped address
    foreach (ra[i]) begin
      cpu_u.sfr(1'b0, ra[i], 8'h00, sq);
      cmp8(sq, rv[i]);
    end
    // Aux register keeps its fields, unused bits read zero
    sd = 8'($urandom());
    cpu_u.sfr(1'b1, eebw_pkg::AUX_ADDR, sd, sq);
    cpu_u.sfr(1'b0, eebw_pkg::AUX_ADDR, 8'h00, sq);
    cmp8(sq, sd & 8'hf6);
    cmp8({6'h00, wdc}, {6'h00, sd[7:6]});
    // Any value but the key drops write enable
    for (int i = 0; i < 4; i++) begin
      cpu_u.sfr(1'b1, eebw_pkg::CTRL_ADDR, eebw_pkg::WE_KEY, sq);
      sd = (i == 0) ? 8'he3 : 8'($urandom());
      if (sd == eebw_pkg::WE_KEY) sd = 8'h00;
      cpu_u.sfr(1'b1, eebw_pkg::CTRL_ADDR, sd, sq);
      cmp8({7'h00, we}, 8'h00);
    end
    // Store without enable, then store outside the array page
    cpu_u.xst(16'hee10, 8'h5a, 1'b1);
    @(posedge clock_i);
    cmp8({7'h00, busy}, 8'h00);
    cpu_u.sfr(1'b1, eebw_pkg::CTRL_ADDR, eebw_pkg::WE_KEY, sq);
    cpu_u.xst(16'hff10, 8'h5a, 1'b1);
    @(posedge clock_i);
    cmp8({7'h00, busy}, 8'h00);
    cpu_u.sfr(1'b1, eebw_pkg::CTRL_ADDR, 8'h00, sq);
    // Completed write then timed-out write at boundary and random cells
    for (int i = 0; i < 4; i++) begin
      sd = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom());
      op(sd, 8'($urandom()), i[0] ? 2'h3 : 2'h0);
      op(sd, 8'($urandom()), i[1] ? 2'h2 : 2'h1);
    end
    final_report();
  end
endmodule
`default_nettype wire
